// ==== hdl/nfc_host.sv ====
`timescale 1ns/1ps

// ==========================================================
// Write data buffer
module nfc_fifo import nfc_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // Pointers
	logic [AW:0] cnt_q, cnt_d; // Fill level
	logic rdy_q, rdy_d; // Registered not-full
	logic push, pop;

	// Next pointers and level
	always_comb begin
		push = in_valid && rdy_q;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		rdy_d = cnt_d < (AW+1)'(DEPTH);
	end

	// Register state; memory written on push
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	assign in_ready = rdy_q;
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];
endmodule

// ==========================================================
// Host sequencer driving the flash pins
module nfc_host import nfc_pkg::*; #(
	parameter int LEN_W = 13,
	parameter int FIFO_DEPTH = 32,
	parameter int T_R_LIM = T_R_CYC,
	parameter int T_DCR1_LIM = T_DCR1_CYC,
	parameter int T_PROG_LIM = T_PROG_CYC,
	parameter int T_DCW2_LIM = T_DCW2_CYC,
	parameter int T_RST_MAX_LIM = T_RST_MAX_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command request
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_op,
	input wire logic [39:0] cmd_addr,
	input wire logic [LEN_W-1:0] cmd_len,
	// Write data stream
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	// Read data and completion
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic err,
	output logic timeout,
	// Flash pins
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic read_strobe_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_in,
	input wire logic ready_busy_n
);
	// ==========================================================
	// State
	nfc_state_t st_q, st_d, ret_q, ret_d; // Main and post-gap state
	nfc_op_t op_q, op_d, op_in; // Operation in flight
	logic [7:0] cyc_q, cyc_d, gap_q, gap_d; // Pin cycle and gap counters
	logic [TMR_W-1:0] tmr_q, tmr_d, lim_q, lim_d; // Busy timer and limit
	logic [39:0] addr_q, addr_d;
	logic [2:0] aidx_q, aidx_d, ppc_q, ppc_d; // Address index, partial count
	logic [LEN_W-1:0] len_q, len_d, cnt_q, cnt_d;
	logic [23:0] row_q, row_d; // Last programmed row
	logic copen_q, copen_d, sok_q, sok_d, ferr_q, ferr_d, ftmo_q, ftmo_d;
	logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, rds_n_q, rds_n_d;
	logic wp_n_q, wp_n_d; // Write protect, held low until the first edge after reset
	logic oe_q, oe_d, rdy_q, rdy_d, rdv_q, rdv_d, done_q, done_d;
	logic err_q, err_d, tmo_q, tmo_d;
	logic [7:0] io_q, io_d, rdd_q, rdd_d;
	logic rb_s1_q, rb_s2_q; // Busy pin synchroniser
	logic [7:0] io_s1_q, io_s2_q; // Data pin synchroniser
	logic f_valid, f_pop;
	logic [7:0] f_data;
	logic acc, bad, same, wr_st, rd_st, wr_last, rd_last, is_prog;

	nfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// ==========================================================
	// Sequencer next state
	always_comb begin
		st_d = st_q;
		ret_d = ret_q;
		op_d = op_q;
		cyc_d = cyc_q;
		gap_d = gap_q;
		tmr_d = tmr_q;
		lim_d = lim_q;
		addr_d = addr_q;
		aidx_d = aidx_q;
		ppc_d = ppc_q;
		len_d = len_q;
		cnt_d = cnt_q;
		row_d = row_q;
		copen_d = copen_q;
		sok_d = sok_q;
		ferr_d = ferr_q;
		ftmo_d = ftmo_q;
		io_d = io_q;
		rdd_d = rdd_q;
		rdv_d = 1'b0;
		f_pop = 1'b0;
		rdy_d = 1'b0;
		op_in = nfc_op_t'(cmd_op);
		acc = cmd_valid && rdy_q;
		is_prog = op_in == OP_PROG || op_in == OP_CPROG;
		same = cmd_addr[39:ROW_LSB] == row_q && ppc_q != 3'h0;
		// Illegal code, open cache program blocks other ops, page used up
		bad = cmd_op == 3'h7 || (copen_q && !is_prog && op_in != OP_CEND)
			|| (is_prog && same && ppc_q == PPC_MAX);
		wr_st = st_q inside {S_CMD1, S_ADDR, S_WDAT, S_CMD2, S_RSTC};
		rd_st = st_q inside {S_RDAT, S_STAT};
		wr_last = wr_st && cyc_q == WR_END - 8'h01;
		rd_last = rd_st && cyc_q == RD_END - 8'h01;
		// Pin cycle counter; data phase stalls while the buffer is empty
		if (wr_last || rd_last || !(wr_st || rd_st)) begin
			cyc_d = 8'h00;
		end else if (st_q == S_WDAT && cyc_q == 8'h00 && !f_valid) begin
			cyc_d = 8'h00;
		end else begin
			cyc_d = cyc_q + 8'h01;
		end
		// Byte placed on the port at the start of each write cycle
		if (wr_st && cyc_q == 8'h00) begin
			unique case (st_q)
				S_CMD1: begin
					unique case (op_q)
						OP_READ: io_d = CMD_READ1;
						OP_CREAD: io_d = CMD_CREAD;
						OP_CLAST: io_d = CMD_CLAST;
						OP_CEND: io_d = CMD_STATUS;
						OP_RESET: io_d = CMD_RESET;
						default: io_d = CMD_PROG1;
					endcase
				end
				S_ADDR: io_d = addr_q[{aidx_q, 3'b000} +: 8];
				S_WDAT: begin
					f_pop = f_valid;
					io_d = f_valid ? f_data : io_q;
				end
				S_CMD2: io_d = op_q == OP_READ ? CMD_READ2 : (op_q == OP_PROG ? CMD_PROG2 : CMD_CPROG2);
				default: io_d = CMD_RESET;
			endcase
		end
		unique case (st_q)
			// Accept or refuse a request
			S_IDLE: begin
				rdy_d = !acc;
				if (acc) begin
					op_d = op_in;
					addr_d = cmd_addr;
					len_d = cmd_len;
					cnt_d = '0;
					aidx_d = 3'h0;
					tmr_d = '0;
					sok_d = 1'b0;
					ferr_d = bad;
					ftmo_d = 1'b0;
					st_d = bad ? S_DONE : S_CMD1;
					unique case (op_in)
						OP_READ: lim_d = TMR_W'(T_R_LIM);
						OP_CREAD, OP_CLAST: lim_d = TMR_W'(T_DCR1_LIM);
						OP_PROG: lim_d = TMR_W'(T_PROG_LIM);
						OP_RESET: lim_d = TMR_W'(T_RST_MAX_LIM);
						default: lim_d = TMR_W'(T_DCW2_LIM);
					endcase
					if (is_prog && !bad) begin
						ppc_d = same ? ppc_q + 3'h1 : 3'h1;
						row_d = cmd_addr[39:ROW_LSB];
					end
				end
			end
			S_CMD1: begin
				if (wr_last) begin
					if (op_q inside {OP_READ, OP_PROG, OP_CPROG}) begin
						st_d = S_ADDR;
					end else begin
						st_d = S_GAP;
						gap_d = op_q == OP_CEND ? GAP_WHR : GAP_WB;
						ret_d = op_q == OP_CEND ? S_STAT : S_BUSY;
					end
				end
			end
			// Five address bytes, column first then row
			S_ADDR: begin
				if (wr_last) begin
					aidx_d = aidx_q + 3'h1;
					if (aidx_q == ADDR_LAST) begin
						st_d = (op_q != OP_READ && len_q != '0) ? S_WDAT : S_CMD2;
					end
				end
			end
			S_WDAT: begin
				if (wr_last) begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_d == len_q) begin
						st_d = S_CMD2;
					end
				end
			end
			S_CMD2, S_RSTC: begin
				if (wr_last) begin
					st_d = S_GAP;
					gap_d = GAP_WB;
					ret_d = S_BUSY;
				end
			end
			S_GAP: begin
				gap_d = gap_q - 8'h01;
				if (gap_q == 8'h01) begin
					st_d = ret_q;
				end
			end
			// Wait for ready with a bound per operation
			S_BUSY: begin
				tmr_d = tmr_q + 1'b1;
				if (rb_s2_q) begin
					if (op_q inside {OP_READ, OP_CREAD, OP_CLAST} && len_q != '0) begin
						st_d = S_GAP;
						gap_d = GAP_RR;
						ret_d = S_RDAT;
					end else begin
						st_d = S_DONE;
					end
				end else if (tmr_q >= lim_q) begin
					ferr_d = 1'b1;
					ftmo_d = 1'b1;
					st_d = S_DONE;
				end
			end
			S_RDAT: begin
				if (rd_last) begin
					rdv_d = 1'b1;
					rdd_d = io_s2_q;
					cnt_d = cnt_q + 1'b1;
					if (cnt_d == len_q) begin
						st_d = S_DONE;
					end
				end
			end
			// Poll status until the earlier program is finished
			S_STAT: begin
				tmr_d = tmr_q + 1'b1;
				if (rd_last && io_s2_q[STAT_RDY_BIT]) begin
					sok_d = 1'b1;
					tmr_d = '0;
					lim_d = TMR_W'(T_RST_RDY_CYC);
					st_d = S_GAP;
					gap_d = GAP_RHW;
					ret_d = S_RSTC;
				end else if (tmr_q >= lim_q) begin
					ferr_d = 1'b1;
					ftmo_d = 1'b1;
					st_d = S_DONE;
				end
			end
			S_DONE: begin
				rdy_d = 1'b1;
				st_d = S_IDLE;
				if (!ferr_q) begin
					copen_d = op_q == OP_CPROG ? 1'b1 : (op_q inside {OP_PROG, OP_CEND, OP_RESET} ? 1'b0 : copen_q);
				end
			end
		endcase
		// Pin levels follow the registered state one cycle later
		we_n_d = !(wr_st && cyc_q >= WR_SET && cyc_q < WR_SET + WR_LO);
		rds_n_d = !(rd_st && cyc_q < RD_LO);
		wp_n_d = 1'b1;
		cle_d = st_q inside {S_CMD1, S_CMD2, S_RSTC};
		ale_d = st_q == S_ADDR;
		oe_d = wr_st;
		ce_n_d = st_q == S_IDLE;
		done_d = st_q == S_DONE;
		err_d = st_q == S_DONE ? ferr_q : err_q;
		tmo_d = st_q == S_DONE ? ftmo_q : tmo_q;
	end

	// ==========================================================
	// Registers and pin synchronisers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			ret_q <= S_IDLE;
			op_q <= OP_READ;
			{cyc_q, gap_q, io_q, rdd_q, io_s1_q, io_s2_q} <= '0;
			{tmr_q, lim_q, addr_q, aidx_q, ppc_q, len_q, cnt_q, row_q} <= '0;
			{copen_q, sok_q, ferr_q, ftmo_q, cle_q, ale_q, oe_q, rdy_q} <= '0;
			{rdv_q, done_q, err_q, tmo_q, rb_s1_q, rb_s2_q} <= '0;
			{ce_n_q, we_n_q, rds_n_q} <= 3'b111;
			wp_n_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ret_q <= ret_d;
			op_q <= op_d;
			{cyc_q, gap_q, io_q, rdd_q} <= {cyc_d, gap_d, io_d, rdd_d};
			{tmr_q, lim_q, addr_q, aidx_q, ppc_q} <= {tmr_d, lim_d, addr_d, aidx_d, ppc_d};
			{len_q, cnt_q, row_q} <= {len_d, cnt_d, row_d};
			{copen_q, sok_q, ferr_q, ftmo_q} <= {copen_d, sok_d, ferr_d, ftmo_d};
			{ce_n_q, cle_q, ale_q, we_n_q, rds_n_q, oe_q} <= {ce_n_d, cle_d, ale_d, we_n_d, rds_n_d, oe_d};
			wp_n_q <= wp_n_d;
			{rdy_q, rdv_q, done_q, err_q, tmo_q} <= {rdy_d, rdv_d, done_d, err_d, tmo_d};
			// Second stages are the only readers of the first
			{rb_s1_q, rb_s2_q} <= {ready_busy_n, rb_s1_q};
			{io_s1_q, io_s2_q} <= {nand_io_in, io_s1_q};
		end
	end

	assign cmd_ready = rdy_q;
	assign rd_valid = rdv_q;
	assign rd_data = rdd_q;
	assign done = done_q;
	assign err = err_q;
	assign timeout = tmo_q;
	assign nand_ce_n = ce_n_q;
	assign nand_cle = cle_q;
	assign nand_ale = ale_q;
	assign nand_we_n = we_n_q;
	assign read_strobe_n = rds_n_q;
	assign nand_wp_n = wp_n_q; // Registered: reset pulls the pin low at once, release waits for a clock edge
	assign nand_io_out = io_q;
	assign nand_io_oe = oe_q;

	// ==========================================================
	// Checks
	logic [2:0] ale_cnt_q; // Address strobes since last command
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ale_cnt_q <= 3'h0;
		end else if (cle_q) begin
			ale_cnt_q <= 3'h0;
		end else if (ale_q && !we_n_d && we_n_q) begin
			ale_cnt_q <= ale_cnt_q + 3'h1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_reset_issue;
		st_q == S_RSTC && cyc_q == 8'h00;
	endsequence
	sequence s_refused;
		done_q && err_q;
	endsequence
	chk_part_prog_limit: assert property (st_q == S_CMD2 && op_q != OP_READ
		|-> ppc_q <= PPC_MAX && ppc_q != 3'h0)
		else $error("partial program count out of range");
	chk_cache_refuse: assert property (acc && bad |-> ##[1:3] s_refused)
		else $error("illegal request not refused");
	chk_status_first: assert property (st_q == S_RSTC && op_q == OP_CEND |-> sok_q)
		else $error("reset sent before status showed ready");
	chk_reset_follows: assert property ($rose(sok_q) |-> ##[1:12] s_reset_issue)
		else $error("reset not issued after ready status");
	chk_cmd_latch: assert property ($rose(nand_we_n) && nand_cle |-> nand_io_oe && !nand_ale)
		else $error("command latched without port driven");
	chk_we_pulse: assert property ($fell(nand_we_n) |-> (!nand_we_n)[*3] ##1 nand_we_n)
		else $error("write pulse width wrong");
	chk_addr_five: assert property ($fell(nand_ale) |-> ale_cnt_q == 3'h5)
		else $error("address phase not five bytes");
	chk_busy_timeout: assert property (st_q == S_BUSY && !rb_s2_q && tmr_q >= lim_q
		|-> ##2 (s_refused and timeout))
		else $error("busy timeout not reported");
endmodule

// ==== pkg/nfc_pkg.sv ====
// ==========================================================
// Host-side constants for the byte-wide flash link
package nfc_pkg;
	// ==========================================================
	// Clock and conversion
	localparam int CLK_MHZ = 200; // Core clock rate
	localparam int NS_PER_US = 1000;
	localparam int SYNC_STAGES = 2; // Pin synchroniser depth
	// Pin timing in ns, least values except T_REA_NS, a longest value
	localparam int T_CS_NS = 20;
	localparam int T_WP_NS = 12;
	localparam int T_WH_NS = 10;
	localparam int T_REA_NS = 20; // Longest access, waited out in full
	localparam int T_REH_NS = 10;
	localparam int T_WB_NS = 100;
	localparam int T_WHR_NS = 60;
	localparam int T_RHW_NS = 30;
	localparam int T_RR_NS = 20;
	// Cycle counts, rounded up
	localparam logic [7:0] WR_SET = 8'(((T_CS_NS - T_WP_NS) * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] WR_LO = 8'((T_WP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] WR_HI = 8'((T_WH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] WR_END = WR_SET + WR_LO + WR_HI;
	localparam logic [7:0] RD_LO = 8'((T_REA_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US + SYNC_STAGES);
	localparam logic [7:0] RD_HI = 8'((T_REH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] RD_END = RD_LO + RD_HI;
	localparam logic [7:0] GAP_WB = 8'((T_WB_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] GAP_WHR = 8'((T_WHR_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] GAP_RHW = 8'((T_RHW_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [7:0] GAP_RR = 8'((T_RR_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	// ==========================================================
	// Busy limits in us and their cycle counts
	localparam int T_R_US = 25; // Array read
	localparam int T_DCR1_US = 25; // Cache read busy
	localparam int T_PROG_US = 700; // Page program
	localparam int T_DCW2_US = 700; // Cache program busy
	localparam int T_RST_RDY_US = 5; // Reset from ready
	localparam int T_RST_MAX_US = 500; // Reset from erase, worst case
	localparam int T_R_CYC = T_R_US * CLK_MHZ;
	localparam int T_DCR1_CYC = T_DCR1_US * CLK_MHZ;
	localparam int T_PROG_CYC = T_PROG_US * CLK_MHZ;
	localparam int T_DCW2_CYC = T_DCW2_US * CLK_MHZ;
	localparam int T_RST_RDY_CYC = T_RST_RDY_US * CLK_MHZ;
	localparam int T_RST_MAX_CYC = T_RST_MAX_US * CLK_MHZ;
	localparam int TMR_W = 18; // Holds the largest busy count
	// ==========================================================
	// Command bytes, addressing, status
	localparam logic [7:0] CMD_READ1 = 8'h00;
	localparam logic [7:0] CMD_READ2 = 8'h30;
	localparam logic [7:0] CMD_CREAD = 8'h31;
	localparam logic [7:0] CMD_CLAST = 8'h3f;
	localparam logic [7:0] CMD_PROG1 = 8'h80;
	localparam logic [7:0] CMD_PROG2 = 8'h10;
	localparam logic [7:0] CMD_CPROG2 = 8'h15;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [2:0] ADDR_LAST = 3'h4; // Five address bytes, index 0..4
	localparam int ROW_LSB = 16; // Row bytes start at third byte
	localparam logic [2:0] PPC_MAX = 3'h4; // Partial programs per page
	localparam int STAT_RDY_BIT = 5; // Ready bit on pin I/O6
	// ==========================================================
	// Operations and states
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_CREAD = 3'h1,
		OP_CLAST = 3'h2,
		OP_PROG = 3'h3,
		OP_CPROG = 3'h4,
		OP_CEND = 3'h5,
		OP_RESET = 3'h6
	} nfc_op_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CMD1 = 4'h1,
		S_ADDR = 4'h2,
		S_WDAT = 4'h3,
		S_CMD2 = 4'h4,
		S_GAP = 4'h5,
		S_BUSY = 4'h6,
		S_RDAT = 4'h7,
		S_STAT = 4'h8,
		S_RSTC = 4'h9,
		S_DONE = 4'ha
	} nfc_state_t;
endpackage

// ==== verification/nfc_flash_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Behavioural flash device seen from the host pins
module nfc_flash_model import nfc_pkg::*; #(
	parameter int BUSY_NS = 200
) (
	// Strobes from the host
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic rd_strobe_n,
	input wire logic [7:0] io_in,
	// Answer to the host
	output logic [7:0] io_out,
	output logic rdy
);
	logic [7:0] cmd_log[$]; // Command bytes seen
	logic [7:0] addr_log[$]; // Address bytes seen
	logic [7:0] dat_log[$]; // Write data seen
	logic [12:0] col = '0; // Column pointer
	logic stat_mode = 1'b0; // Status byte selected
	logic drive = 1'b0; // Output drivers on
	logic stuck = 1'b0; // Bench holds busy to stretch a status poll or provoke a timeout
	logic busy = 1'b0; // Array operation in progress
	logic [7:0] last = 8'h00; // Last byte driven
	// Released port shows the inverse, so a late sample never matches by luck
	assign io_out = drive ? last : ~last;
	// Open-drain busy pin with pull-up: low while operating
	assign rdy = !busy && !stuck;
	// ==========================================================
	// Latching on the write strobe rise
	always @(posedge we_n) begin
		if (!ce_n && cle) begin // Command captured with latch enable high
			cmd_log.push_back(io_in);
			stat_mode = (io_in == CMD_STATUS);
			if (io_in == CMD_CREAD) col = '0; // Cache read restarts column
			// Every busy span stays below each documented maximum
			if (io_in inside {CMD_READ2, CMD_CREAD, CMD_CLAST, CMD_PROG2, CMD_CPROG2, CMD_RESET}) begin
				fork
					begin
						busy = 1'b1;
						#(BUSY_NS);
						busy = 1'b0;
					end
				join_none
			end
		end else if (!ce_n && ale) begin // Two column then three row bytes
			addr_log.push_back(io_in);
			if (addr_log.size() % 5 == 1) col[7:0] = io_in;
			if (addr_log.size() % 5 == 2) col[12:8] = io_in[4:0];
		end else if (!ce_n) begin
			dat_log.push_back(io_in);
		end
	end
	// ==========================================================
	// Serial output on read strobe fall, ready bit on I/O6
	always @(negedge rd_strobe_n) begin
		if (!ce_n) begin
			last = stat_mode ? (8'h80 | {2'b00, rdy, 5'h00}) : (8'ha5 ^ col[7:0]);
			drive = 1'b1;
			if (!stat_mode) col = col + 13'h1;
		end
	end
	// Long strobe high: hold 25 ns, then release
	always @(posedge rd_strobe_n) begin
		#25;
		if (rd_strobe_n) drive = 1'b0;
	end
	// Short strobe high: other strobes end the drive
	always @(posedge cle or posedge ale or posedge ce_n or negedge we_n) drive = 1'b0;
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the flash host sequencer
module tb_top import nfc_pkg::*; ;
	logic core_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0;
	logic [2:0] cmd_op = '0;
	logic [39:0] cmd_addr = '0;
	logic [12:0] cmd_len = '0;
	logic [7:0] wr_data = '0, rd_data, io_out, io_in, flash_io;
	logic cmd_ready, wr_ready, rd_valid, done, err, timeout, rdy;
	logic ce_n, cle, ale, we_n, rd_strobe_n, wp_n, io_oe;
	logic [7:0] rdq[$]; // Bytes returned by the last request
	int fail_count = 0, total_checks = 0;
	// Shared port: host drive wins, else whatever the device shows
	assign io_in = io_oe ? io_out : flash_io;
	nfc_host #(.T_R_LIM(200), .T_DCR1_LIM(200), .T_PROG_LIM(200), .T_DCW2_LIM(200),
		.T_RST_MAX_LIM(200)) dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .err(err), .timeout(timeout), .nand_ce_n(ce_n),
		.nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(rd_strobe_n),
		.nand_wp_n(wp_n), .nand_io_out(io_out), .nand_io_oe(io_oe), .nand_io_in(io_in),
		.ready_busy_n(rdy));
	nfc_flash_model fl (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .rd_strobe_n(rd_strobe_n),
		.io_in(io_in), .io_out(flash_io), .rdy(rdy));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic clr;
		fl.cmd_log.delete();
		fl.addr_log.delete();
		fl.dat_log.delete();
	endtask
	// Request held until taken, then bytes gathered until done
	task automatic run(input logic [2:0] op, input logic [39:0] a, input logic [12:0] n);
		int k;
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_len = n;
		@(posedge core_clk);
		while (cmd_ready !== 1'b1) @(posedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		rdq.delete();
		for (k = 0; k < 20000 && done !== 1'b1; k++) begin
			if (rd_valid === 1'b1) rdq.push_back(rd_data);
			@(negedge core_clk);
		end
		if (k == 20000) fail_count++;
	endtask
	// ==========================================================
	// Scenarios
	task automatic s_read;
		int i;
		clr;
		run(3'h0, 40'h0002010003, 13'h2);
		check(err, 1'b0);
		check(rdq.size(), 2);
		check(rdq[0], 8'ha6);
		check(rdq[1], 8'ha1);
		check(fl.cmd_log[0], CMD_READ1);
		check(fl.cmd_log[1], CMD_READ2);
		for (i = 0; i < 5; i++) check(fl.addr_log[i], 8'(40'h0002010003 >> (8 * i)));
		clr;
		run(3'h1, 40'h0, 13'h1);
		check(fl.cmd_log[0], CMD_CREAD);
		check(rdq[0], 8'ha5);
		// Last cache read keeps the column running from the previous byte
		clr;
		run(3'h2, 40'h0, 13'h1);
		check(fl.cmd_log[0], CMD_CLAST);
		check(rdq[0], 8'ha4);
	endtask
	// Fill the buffer until it refuses, then drain it through a program
	task automatic s_fifo;
		int i;
		clr;
		for (i = 0; i < 32; i++) begin
			@(negedge core_clk);
			wr_valid = 1'b1;
			wr_data = 8'h40 + 8'(i);
			@(posedge core_clk);
			while (wr_ready !== 1'b1) @(posedge core_clk);
		end
		@(negedge core_clk);
		wr_valid = 1'b0;
		check(wr_ready, 1'b0);
		run(3'h3, 40'h0005000000, 13'd32);
		check(wr_ready, 1'b1);
		check(fl.dat_log.size(), 32);
		for (i = 0; i < 32; i++) check(fl.dat_log[i], 8'h40 + 8'(i));
		check(fl.cmd_log[0], CMD_PROG1);
		check(fl.cmd_log[1], CMD_PROG2);
	endtask
	// Fifth partial program to one page is refused without pin traffic
	task automatic s_partial;
		int i;
		clr;
		for (i = 0; i < 5; i++) begin
			run(3'h3, 40'h0007000000, 13'h0);
			check(err, (i == 4));
		end
		check(fl.cmd_log.size(), 8);
	endtask
	// Cache program end: polls status while busy, then resets
	task automatic s_cache;
		run(3'h4, 40'h0009000000, 13'h0);
		check(err, 1'b0);
		run(3'h1, 40'h0, 13'h1);
		check(err, 1'b1);
		clr;
		fl.stuck = 1'b1;
		fork
			#600 fl.stuck = 1'b0;
		join_none
		run(3'h5, 40'h0, 13'h0);
		check({err, timeout}, 2'b00);
		check(fl.cmd_log[0], CMD_STATUS);
		check(fl.cmd_log[fl.cmd_log.size() - 1], CMD_RESET);
	endtask
	// Busy that never ends is cut short; reset and illegal ops follow
	task automatic s_fault;
		fl.stuck = 1'b1;
		run(3'h0, 40'h0, 13'h1);
		check(timeout, 1'b1);
		fl.stuck = 1'b0;
		clr;
		run(3'h6, 40'h0, 13'h0);
		check({err, timeout}, 2'b00);
		check(fl.cmd_log[0], CMD_RESET);
		clr;
		run(3'h7, 40'h0, 13'h0);
		check(err, 1'b1);
		check(fl.cmd_log.size(), 0);
	endtask
	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		@(negedge core_clk);
		check(ce_n, 1'b1);
		check(wp_n, 1'b1);
		s_read;
		s_fifo;
		s_partial;
		s_cache;
		s_fault;
		close_out;
	end
	initial begin
		#400000;
		fail_count++;
		close_out;
	end
endmodule
